// ==== src/rtc_alarm_defs.vh ====
// Register offsets, field positions, reset values and timing counts for the alarm unit
`ifndef RTC_ALARM_DEFS_VH
`define RTC_ALARM_DEFS_VH

`define STATUS_ADDR      8'h07
`define CONTROL_ADDR     8'h08
`define ALARM_BASE_ADDR  8'h10
`define ALARM_LAST_ADDR  8'h15
`define ALARM_FIELDS     6

`define ALARM_FLAG_BIT   4
`define AUTO_CLEAR_BIT   7
`define INT_MODE_BIT     6
`define FIELD_ENABLE_BIT 7

`define CONTROL_RESET    8'h00
`define ALARM_RESET      8'h00
`define DEVICE_ADDR      7'h5A // Arbitrary bus address

`define CLK_PERIOD_NS    40
`define IRQ_PULSE_NS     1000
`define IRQ_PULSE_CYCLES ((`IRQ_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ==== src/alarm_match_bank.v ====
// Six alarm match bytes with registered read port and parallel view for the comparator
`timescale 1ns/1ps
`include "rtc_alarm_defs.vh"
module alarm_match_bank #(
    parameter FIELDS = 6
) (
    input  wire                 clk,
    input  wire                 sys_rst,
    input  wire                 wr_en,
    input  wire [2:0]           wr_idx,
    input  wire [7:0]           wr_data,
    input  wire [2:0]           rd_idx,
    output reg  [7:0]           rd_data,
    output wire [8*FIELDS-1:0]  all_bytes
);
    reg [7:0] mem_reg [0:FIELDS-1];

    genvar g;
    generate
        for (g = 0; g < FIELDS; g = g + 1) begin : field
            always @(posedge clk) begin
                if (sys_rst) begin
                    mem_reg[g] <= `ALARM_RESET;
                end else if (wr_en && wr_idx == g) begin
                    mem_reg[g] <= wr_data;
                end
            end
            assign all_bytes[8*g+7:8*g] = mem_reg[g];
        end
    endgenerate

    // Out-of-range index reads zero rather than aliasing another field
    always @(posedge clk) begin
        if (sys_rst) begin
            rd_data <= 8'h00;
        end else if (rd_idx < FIELDS) begin
            rd_data <= mem_reg[rd_idx];
        end else begin
            rd_data <= 8'h00;
        end
    end
endmodule

// ==== src/rtc_alarm_compare.v ====
// Alarm compare unit with two-wire slave register port and interrupt output
//
// What this block does
// RULE1: Alarm bytes mirror time byte encoding; the top bit is the field enable.
// RULE2: Only fields whose top bit is one take part in the comparison.
// RULE3: There is no year alarm field; year never compared.
// RULE4: Alarm event when every enabled field equals current time as time advances.
// RULE5: Any mix of one to all six enabled fields is supported.
// RULE6: Alarm bytes sit at 10h..15h: seconds, minutes, hours, date, month, weekday.
// RULE7: Host enables a field, clears mode bit and disables frequency output for single-event.
// RULE8: Single-event match sets the flag and holds interrupt low until flag cleared.
// RULE9: Mode bit one: interrupt pulses on every match, no reconfiguration needed.
// RULE10: Writing zero to the status flag clears it and releases the interrupt.
// RULE11: With auto-clear bit 7 of 08h set, a status read clears the flag.
// RULE12: Periodic mode sets the flag each time but pulses regardless of the flag.
// RULE13: Bytes move over the two-wire bus as slave only, most significant bit first.
// RULE14: Comparison runs once per seconds update, one event per matching second.
`timescale 1ns/1ps
`include "rtc_alarm_defs.vh"
module rtc_alarm_compare #(
    parameter [6:0] DEV_ADDR     = `DEVICE_ADDR,
    parameter       PULSE_CYCLES = `IRQ_PULSE_CYCLES
) (
    input  wire       clk,
    input  wire       sys_rst,
    input  wire       scl_in,
    input  wire       sda_in,
    output wire       sda_out,
    output reg        sda_oe,
    input  wire       sec_tick,
    input  wire [7:0] time_sec,
    input  wire [7:0] time_min,
    input  wire [7:0] time_hour,
    input  wire [7:0] time_date,
    input  wire [7:0] time_month,
    input  wire [7:0] time_weekday,
    input  wire       fout_enable,
    output reg        irq_n
);
    localparam [2:0] ST_IDLE  = 3'h0;
    localparam [2:0] ST_ADDR  = 3'h1;
    localparam [2:0] ST_PTR   = 3'h2;
    localparam [2:0] ST_WDATA = 3'h3;
    localparam [2:0] ST_READ  = 3'h4;
    localparam [2:0] ST_RACK  = 3'h5;

    reg  [2:0]  state_reg;
    reg  [2:0]  bit_cnt_reg;
    reg  [7:0]  shift_reg;
    reg  [7:0]  ptr_reg;
    reg         rw_reg;
    reg         byte_full_reg;
    reg         ack_reg;
    reg         load_next_reg;
    reg         scl_d_reg;
    reg         sda_d_reg;
    reg  [7:0]  control_reg;
    reg         alarm_flag_reg;
    reg         alarm_flag_next;
    reg         alarm_hit_reg;
    reg  [15:0] pulse_cnt_reg;
    reg         wr_fire;
    reg         rd_status_fire;
    reg  [7:0]  read_byte;

    wire        scl_rise = scl_in & ~scl_d_reg;
    wire        scl_fall = ~scl_in & scl_d_reg;
    wire        start_cond = scl_in & scl_d_reg & sda_d_reg & ~sda_in;
    wire        stop_cond = scl_in & scl_d_reg & ~sda_d_reg & sda_in;
    wire        ptr_in_alarm = (ptr_reg >= `ALARM_BASE_ADDR) && (ptr_reg <= `ALARM_LAST_ADDR);
    wire [7:0]  ptr_offset = ptr_reg - `ALARM_BASE_ADDR;
    wire [2:0]  alarm_idx = ptr_in_alarm ? ptr_offset[2:0] : 3'h7;
    wire [7:0]  bank_rd_data;
    wire [47:0] alarm_bytes;
    wire [47:0] time_bytes = {time_weekday, time_month, time_date, time_hour, time_min, time_sec}; // RULE3
    wire        auto_clear_on_read = control_reg[`AUTO_CLEAR_BIT];
    wire        interrupt_mode_select = control_reg[`INT_MODE_BIT];
    wire [5:0]  field_enable;
    wire [5:0]  field_hit;

    // Open-drain data line: only ever pulled low
    assign sda_out = 1'b0; // RULE13

    alarm_match_bank #(
        .FIELDS    (`ALARM_FIELDS)
    ) u_bank (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .wr_en     (wr_fire & ptr_in_alarm), // RULE6
        .wr_idx    (alarm_idx),
        .wr_data   (shift_reg),
        .rd_idx    (alarm_idx),
        .rd_data   (bank_rd_data),
        .all_bytes (alarm_bytes)
    );

    genvar g;
    generate
        for (g = 0; g < `ALARM_FIELDS; g = g + 1) begin : cmp
            assign field_enable[g] = alarm_bytes[8*g+`FIELD_ENABLE_BIT]; // RULE1
            // Disabled fields always count as hits
            assign field_hit[g] = ~field_enable[g] | (alarm_bytes[8*g+6:8*g] == time_bytes[8*g+6:8*g]); // RULE2
        end
    endgenerate

    // Byte presented to the master for the current pointer
    always @* begin
        if (ptr_reg == `STATUS_ADDR) begin
            read_byte = 8'h00;
            read_byte[`ALARM_FLAG_BIT] = alarm_flag_reg;
        end else if (ptr_reg == `CONTROL_ADDR) begin
            read_byte = control_reg;
        end else if (ptr_in_alarm) begin
            read_byte = bank_rd_data;
        end else begin
            read_byte = 8'h00;
        end
    end

    always @(posedge clk) begin
        if (sys_rst) begin
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
        end else begin
            scl_d_reg <= scl_in;
            sda_d_reg <= sda_in;
        end
    end

    // Slave-only byte engine, most significant bit first
    always @(posedge clk) begin
        if (sys_rst) begin
            state_reg      <= ST_IDLE;
            bit_cnt_reg    <= 3'h0;
            shift_reg      <= 8'h00;
            ptr_reg        <= 8'h00;
            rw_reg         <= 1'b0;
            byte_full_reg  <= 1'b0;
            ack_reg        <= 1'b0;
            load_next_reg  <= 1'b0;
            sda_oe         <= 1'b0;
            wr_fire        <= 1'b0;
            rd_status_fire <= 1'b0;
            control_reg    <= `CONTROL_RESET;
        end else begin
            wr_fire        <= 1'b0;
            rd_status_fire <= 1'b0;
            if (wr_fire) begin
                if (ptr_reg == `CONTROL_ADDR) begin
                    control_reg <= shift_reg;
                end
                ptr_reg <= ptr_reg + 8'h01;
            end
            if (start_cond) begin
                state_reg     <= ST_ADDR;
                bit_cnt_reg   <= 3'h0;
                byte_full_reg <= 1'b0;
                ack_reg       <= 1'b0;
                load_next_reg <= 1'b0;
                sda_oe        <= 1'b0;
            end else if (stop_cond) begin
                state_reg <= ST_IDLE;
                ack_reg   <= 1'b0;
                sda_oe    <= 1'b0;
            end else begin
                case (state_reg)
                    ST_ADDR, ST_PTR, ST_WDATA: begin
                        if (scl_rise && !ack_reg && !byte_full_reg) begin
                            shift_reg   <= {shift_reg[6:0], sda_in}; // RULE13
                            bit_cnt_reg <= bit_cnt_reg + 3'h1;
                            if (bit_cnt_reg == 3'h7) begin
                                byte_full_reg <= 1'b1;
                            end
                        end else if (scl_fall && byte_full_reg) begin
                            byte_full_reg <= 1'b0;
                            if (state_reg == ST_ADDR && shift_reg[7:1] != DEV_ADDR) begin
                                state_reg <= ST_IDLE;
                            end else begin
                                ack_reg <= 1'b1;
                                sda_oe  <= 1'b1;
                                if (state_reg == ST_ADDR) begin
                                    rw_reg <= shift_reg[0];
                                end else if (state_reg == ST_PTR) begin
                                    ptr_reg <= shift_reg;
                                end else begin
                                    wr_fire <= 1'b1;
                                end
                            end
                        end else if (scl_fall && ack_reg) begin
                            ack_reg <= 1'b0;
                            sda_oe  <= 1'b0;
                            if (state_reg == ST_ADDR && rw_reg) begin
                                state_reg      <= ST_READ;
                                shift_reg      <= read_byte;
                                sda_oe         <= ~read_byte[7];
                                rd_status_fire <= (ptr_reg == `STATUS_ADDR);
                                ptr_reg        <= ptr_reg + 8'h01;
                            end else if (state_reg == ST_ADDR) begin
                                state_reg <= ST_PTR;
                            end else begin
                                state_reg <= ST_WDATA;
                            end
                        end
                    end
                    ST_READ: begin
                        if (scl_fall) begin
                            if (bit_cnt_reg == 3'h7) begin
                                sda_oe    <= 1'b0;
                                state_reg <= ST_RACK;
                            end else begin
                                sda_oe    <= ~shift_reg[6];
                                shift_reg <= {shift_reg[6:0], 1'b0};
                            end
                            bit_cnt_reg <= bit_cnt_reg + 3'h1;
                        end
                    end
                    ST_RACK: begin
                        if (scl_rise) begin
                            if (sda_in) begin
                                state_reg <= ST_IDLE;
                            end else begin
                                load_next_reg <= 1'b1;
                            end
                        end else if (scl_fall && load_next_reg) begin
                            load_next_reg  <= 1'b0;
                            state_reg      <= ST_READ;
                            bit_cnt_reg    <= 3'h0;
                            shift_reg      <= read_byte;
                            sda_oe         <= ~read_byte[7];
                            rd_status_fire <= (ptr_reg == `STATUS_ADDR);
                            ptr_reg        <= ptr_reg + 8'h01;
                        end
                    end
                    default: begin
                        sda_oe <= 1'b0;
                    end
                endcase
            end
        end
    end

    // Compare only on the seconds update so one matching second gives one event
    always @(posedge clk) begin
        if (sys_rst) begin
            alarm_hit_reg <= 1'b0;
        end else begin
            alarm_hit_reg <= sec_tick & (|field_enable) & (&field_hit); // RULE4 RULE5 RULE14
        end
    end

    // Hardware set wins over any clear arriving in the same cycle
    always @* begin
        alarm_flag_next = alarm_flag_reg;
        if (wr_fire && ptr_reg == `STATUS_ADDR && !shift_reg[`ALARM_FLAG_BIT]) begin
            alarm_flag_next = 1'b0; // RULE10
        end
        if (rd_status_fire && auto_clear_on_read) begin
            alarm_flag_next = 1'b0; // RULE11
        end
        if (alarm_hit_reg) begin
            alarm_flag_next = 1'b1; // RULE8 RULE12
        end
    end

    always @(posedge clk) begin
        if (sys_rst) begin
            alarm_flag_reg <= 1'b0;
            pulse_cnt_reg  <= 16'h0000;
            irq_n          <= 1'b1;
        end else begin
            alarm_flag_reg <= alarm_flag_next;
            if (alarm_hit_reg && interrupt_mode_select) begin
                pulse_cnt_reg <= PULSE_CYCLES[15:0]; // RULE9 RULE12
            end else if (pulse_cnt_reg != 16'h0000) begin
                pulse_cnt_reg <= pulse_cnt_reg - 16'h0001;
            end
            // The pin is shared with the frequency output, so the alarm stays off it while that runs
            if (fout_enable) begin
                irq_n <= 1'b1; // RULE7
            end else if (interrupt_mode_select) begin
                irq_n <= ~((alarm_hit_reg) | (pulse_cnt_reg > 16'h0001)); // RULE9
            end else begin
                irq_n <= ~alarm_flag_next; // RULE8
            end
        end
    end
endmodule

// ==== bench/rtc_alarm_compare_asserts.sv ====
// Port-level assertions for the alarm compare unit
`timescale 1ns/1ps
module rtc_alarm_compare_asserts #(
    parameter PULSE_CYCLES = 2
) (
    input wire clk,
    input wire sys_rst,
    input wire scl_in,
    input wire sda_out,
    input wire sda_oe,
    input wire sec_tick,
    input wire fout_enable,
    input wire irq_n
);
    reg [15:0] low_cnt_reg;
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // Saturates so a long single-event hold cannot wrap
    always @(posedge clk) begin
        if (sys_rst || irq_n) low_cnt_reg <= 16'h0000;
        else if (low_cnt_reg != 16'hFFFF) low_cnt_reg <= low_cnt_reg + 16'h0001;
    end
    a_reset_idle:
        assert property ($past(sys_rst) |-> irq_n && !sda_oe) else $error("outputs busy after reset");
    a_sda_open_drain:
        assert property (sda_out == 1'b0) else $error("sda_out not low");
    a_oe_scl_low:
        assert property ($changed(sda_oe) |-> !scl_in) else $error("sda_oe moved while scl high");
    a_irq_after_tick:
        assert property ($fell(irq_n) |-> $past(sec_tick, 2)) else $error("irq_n fell without a tick");
    a_irq_fout_quiet:
        assert property (fout_enable ##1 fout_enable |-> irq_n) else $error("irq_n low with fout on");
    a_fall_fout_off:
        assert property ($fell(irq_n) |-> !$past(fout_enable)) else $error("irq_n fell with fout on");
    a_low_min:
        assert property ($fell(irq_n) && !fout_enable |=> !irq_n || fout_enable) else $error("irq_n glitch");
    a_pulse_width:
        assert property ($rose(irq_n) && !$past(fout_enable) |-> low_cnt_reg >= PULSE_CYCLES)
            else $error("irq_n pulse too short");
endmodule

// ==== bench/i2c_host_model.sv ====
// Two-wire bus master standing in for the host controller
`timescale 1ns/1ps
module i2c_host_model #(
    parameter [6:0] DEV = 7'h5A,
    parameter       Q   = 4
) (
    input  wire clk,
    input  wire sda_line,
    output reg  scl_drv,
    output reg  sda_drv
);
    reg [7:0] rd_val;
    integer   nacks = 0;
    event     rd_done;
    initial begin
        scl_drv = 1'b1;
        sda_drv = 1'b1;
    end
    // Lines only move on the falling clock edge, held for Q cycles
    task step(input s, input d);
        begin
            scl_drv = s;
            sda_drv = d;
            repeat (Q) @(negedge clk);
        end
    endtask
    task xstart;
        begin
            step(1'b0, 1'b1);
            step(1'b1, 1'b1);
            step(1'b1, 1'b0);
            step(1'b0, 1'b0);
        end
    endtask
    task xbit(input b, output r);
        begin
            step(1'b0, b);
            step(1'b1, b);
            r = sda_line;
        end
    endtask
    task xbyte(input [7:0] d, output [7:0] q);
        integer k;
        begin
            for (k = 7; k >= 0; k = k - 1) xbit(d[k], q[k]);
        end
    endtask
    task send(input [7:0] d);
        reg [7:0] q;
        reg       r;
        begin
            xbyte(d, q);
            xbit(1'b1, r);
            if (r) nacks = nacks + 1;
        end
    endtask
    task xstop;
        begin
            step(1'b0, 1'b0);
            step(1'b1, 1'b0);
            step(1'b1, 1'b1);
        end
    endtask
    task wr(input [7:0] a, input [7:0] d);
        begin
            xstart;
            send({DEV, 1'b0});
            send(a);
            send(d);
            xstop;
        end
    endtask
    // Pointer write, repeated start, one byte read ended by a NACK
    task rd(input [7:0] a);
        reg r;
        begin
            xstart;
            send({DEV, 1'b0});
            send(a);
            xstart;
            send({DEV, 1'b1});
            xbyte(8'hFF, rd_val);
            xbit(1'b1, r);
            xstop;
            -> rd_done;
        end
    endtask
endmodule

// ==== bench/tb_rtc_alarm_compare.sv ====
// Self-checking bench for the alarm compare unit
`timescale 1ns/1ps
module tb_rtc_alarm_compare;
    reg         clk;
    reg         sys_rst;
    reg         sec_tick;
    reg         fout_enable;
    reg  [47:0] tv;
    reg  [47:0] tb;
    reg  [5:0]  rm;
    wire        scl_drv;
    wire        sda_drv;
    wire        sda_out;
    wire        sda_oe;
    wire        irq_n;
    wire        sda_line = sda_drv & (sda_oe !== 1'b1);
    reg  [7:0]  exp_q[$];
    integer     bad_count = 0;
    integer     tests_run = 0;
    integer     falls = 0;
    integer     i;
    rtc_alarm_compare #(.PULSE_CYCLES(2)) i_dut (
        .clk(clk), .sys_rst(sys_rst), .scl_in(scl_drv), .sda_in(sda_line), .sda_out(sda_out),
        .sda_oe(sda_oe), .sec_tick(sec_tick), .time_sec(tv[7:0]), .time_min(tv[15:8]),
        .time_hour(tv[23:16]), .time_date(tv[31:24]), .time_month(tv[39:32]),
        .time_weekday(tv[47:40]), .fout_enable(fout_enable), .irq_n(irq_n));
    i2c_host_model i_host (.clk(clk), .sda_line(sda_line), .scl_drv(scl_drv), .sda_drv(sda_drv));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(negedge irq_n) falls = falls + 1;
    task check(input string nm, input [7:0] seen, input [7:0] exp);
        begin
            tests_run = tests_run + 1;
            if (seen !== exp) begin
                bad_count = bad_count + 1;
                $display("unexpected %s: expected %h seen %h", nm, exp, seen);
            end
        end
    endtask
    task end_sim;
        begin
            $display("checks %0d mismatches %0d", tests_run, bad_count);
            if (bad_count == 0 && tests_run > 0)
                $display("ALL TESTS PASSED");
            else
                $display("TESTS FAILED");
            $finish;
        end
    endtask
    task rdx(input [7:0] a, input [7:0] e);
        begin
            exp_q.push_back(e);
            i_host.rd(a);
        end
    endtask
    initial forever begin
        @(i_host.rd_done);
        check("read data", i_host.rd_val, exp_q.pop_front());
    end
    task tick(input [47:0] t);
        begin
            @(negedge clk);
            tv = t;
            sec_tick = 1'b1;
            @(negedge clk);
            sec_tick = 1'b0;
            repeat (6) @(negedge clk);
        end
    endtask
    // Arm mask m, miss on an enabled field, then match twice with disabled fields changed
    task combo(input [5:0] m, input im, input ac);
        reg [47:0] fe;
        reg [47:0] fd;
        integer    k;
        begin
            fe = 48'h000000000000;
            fd = 48'h000000000000;
            for (k = 0; k < 6; k = k + 1) begin
                i_host.wr(8'h10 + k, {m[k], tb[8*k+:7]});
                if (m[k]) fe[8*k] = 1'b1;
                else fd[8*k] = 1'b1;
            end
            falls = 0;
            tick(tb ^ fe);
            check("irq_n miss", {7'h00, irq_n}, 8'h01);
            tick(tb ^ fd);
            tick(tb ^ fd);
            check("irq_n held", {7'h00, irq_n}, {7'h00, im});
            check("irq falls", falls[7:0], im ? 8'h02 : 8'h01);
            rdx(8'h07, 8'h10);
            rdx(8'h07, ac ? 8'h00 : 8'h10);
            check("irq_n read", {7'h00, irq_n}, {7'h00, im | ac});
            i_host.wr(8'h07, 8'h00);
            check("irq_n clear", {7'h00, irq_n}, 8'h01);
            rdx(8'h07, 8'h00);
            $display("test mask %h mode %0d autoclear %0d done", m, im, ac);
        end
    endtask
    initial begin
        sys_rst = 1'b1;
        sec_tick = 1'b0;
        fout_enable = 1'b0;
        tv = 48'h000000000000;
        i = $urandom(32'hba521408);
        repeat (12) @(negedge clk);
        sys_rst = 1'b0;
        rdx(8'h08, 8'h00);
        rdx(8'h07, 8'h00);
        rdx(8'h20, 8'h00);
        for (i = 0; i < 6; i = i + 1) rdx(8'h10 + i, 8'h00);
        $display("test reset values done");
        tb = {$urandom, $urandom};
        for (i = 0; i < 6; i = i + 1) begin
            i_host.wr(8'h10 + i, tb[8*i+:8]);
            rdx(8'h10 + i, tb[8*i+:8]);
        end
        $display("test alarm map done");
        tb = {$urandom, $urandom} & 48'h7F7F7F7F7F7F;
        rm = ($urandom % 63) + 1;
        i_host.wr(8'h08, 8'h00);
        combo(6'h01, 1'b0, 1'b0);
        combo(6'h20, 1'b0, 1'b0);
        combo(6'h3F, 1'b0, 1'b0);
        i_host.wr(8'h08, 8'h40);
        combo(rm, 1'b1, 1'b0);
        combo(6'h3F, 1'b1, 1'b0);
        i_host.wr(8'h08, 8'h80);
        combo(6'h04, 1'b0, 1'b1);
        i_host.wr(8'h08, 8'h00);
        fout_enable = 1'b1;
        tick(tb);
        check("irq_n fout", {7'h00, irq_n}, 8'h01);
        rdx(8'h07, 8'h10);
        i_host.wr(8'h07, 8'h00);
        fout_enable = 1'b0;
        check("nacks", i_host.nacks[7:0], 8'h00);
        $display("test frequency output done");
        // Reset in mid-run must release a held single-event interrupt and wipe the alarm bytes
        tick(tb);
        check("irq_n pre reset", {7'h00, irq_n}, 8'h00);
        @(negedge clk);
        sys_rst = 1'b1;
        repeat (2) @(negedge clk);
        sys_rst = 1'b0;
        check("irq_n reset", {7'h00, irq_n}, 8'h01);
        rdx(8'h07, 8'h00);
        rdx(8'h12, 8'h00);
        $display("test mid-run reset done");
        end_sim;
    end
    initial begin
        #(40 * 80000);
        bad_count = bad_count + 1;
        end_sim;
    end
endmodule
bind rtc_alarm_compare rtc_alarm_compare_asserts #(.PULSE_CYCLES(PULSE_CYCLES)) i_chk (
    .clk(clk), .sys_rst(sys_rst), .scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .sec_tick(sec_tick), .fout_enable(fout_enable), .irq_n(irq_n));
